// [pkg/rgu_pkg.sv]
package rgu_pkg;

  localparam int AREAS      = 4;
  localparam int AW         = 32;
  localparam int RAW        = 8;

  // Access kinds
  localparam logic [1:0] OP_READ   = 2'h0;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_DELETE = 2'h2;
  localparam logic [1:0] OP_EXEC   = 2'h3;

  // Memory kinds
  localparam logic [1:0] MEM_ROM   = 2'h0;
  localparam logic [1:0] MEM_RAM   = 2'h1;
  localparam logic [1:0] MEM_FLASH = 2'h2;

  // Register map (byte offsets)
  localparam logic [RAW-1:0] REG_CTRL   = 8'h00;
  localparam logic [RAW-1:0] REG_STATUS = 8'h04;
  localparam logic [RAW-1:0] REG_VADDR  = 8'h08;
  localparam logic [RAW-1:0] REG_AREA0  = 8'h10;
  localparam int             AREA_STEP  = 16;
  localparam int             OFS_BASE   = 0;
  localparam int             OFS_LIMIT  = 4;
  localparam int             OFS_PERM   = 8;

  // CTRL fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_LOCK_BIT = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // STATUS fields
  localparam int ST_VIOL_BIT = 0;
  localparam int ST_OP_LSB   = 1;
  localparam int ST_PRIV_BIT = 3;
  localparam int ST_DENY_BIT = 4;

  // PERM layout: [3:0] privileged r/w/d/x, [7:4] user r/w/d/x, [9:8] mem kind, [10] valid
  localparam int PERM_U_LSB  = 4;
  localparam int PERM_MEM_LSB = 8;
  localparam int PERM_VAL_BIT = 10;
  localparam logic [3:0] DEF_PRIV_PERM = 4'hF;
  localparam logic [3:0] DEF_USER_PERM = 4'h0;
  localparam logic [31:0] BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
  localparam logic [31:0] PERM_RST  = 32'h0000_0000;

  typedef struct packed {
    logic          valid;
    logic [1:0]    op;
    logic          priv;
    logic [AW-1:0] addr;
    logic [AW-1:0] fetch_addr;
    logic [1:0]    mem;
    logic [31:0]   wdata;
  } rgu_req_t;

  typedef struct packed {
    logic        valid;
    logic        grant;
    logic [31:0] rdata;
  } rgu_rsp_t;

endpackage : rgu_pkg

// [hw/rgu_top.sv]
// How it works
// - Check r/w/delete/exec per privilege mode
// - Areas tagged ROM, RAM or FLASH
// - Decide on fetch area, target, operation
// - Deny before completion, no data returned
// - Only privileged software changes configuration
// - Defaults apply until areas programmed
// - Override defaults only when policy permits
// - Manufacture defaults or run-time programming
// - Software sets area bounds and permissions
// - Configuration readable, writable as registers
module rgu_top (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic [rgu_pkg::RAW-1:0]    reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic                       reg_priv,
  output logic      [31:0]                reg_rdata,
  input  wire rgu_pkg::rgu_req_t          cpu_req,
  output rgu_pkg::rgu_rsp_t               cpu_rsp,
  output rgu_pkg::rgu_req_t               mem_req,
  input  wire logic [31:0]                mem_rdata,
  input  wire logic                       mem_rvalid,
  output logic                            viol
);

  localparam int N = rgu_pkg::AREAS;

  logic [31:0]    base_r  [N];
  logic [31:0]    limit_r [N];
  logic [10:0]    perm_r  [N];
  logic [31:0]    ctrl_r;
  logic           viol_r;
  logic [1:0]     vop_r;
  logic           vpriv_r;
  logic           vdeny_cfg_r;
  logic [31:0]    vaddr_r;
  logic           pend_r;
  logic           pend_rd_r;

  // Area hit decode, one copy per area
  logic [N-1:0] tgt_hit;
  logic [N-1:0] src_hit;
  logic [N-1:0] tgt_ok;
  logic [N-1:0] src_x;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_area
      logic       live;
      logic       tgt_lo;
      logic       tgt_hi;
      logic       src_lo;
      logic       src_hi;
      logic       kind_ok;
      logic [3:0] ppbits;
      logic [3:0] upbits;
      logic [3:0] pbits;
      assign live       = perm_r[g][rgu_pkg::PERM_VAL_BIT];
      // Limit is inclusive so an area can reach the top of the map
      assign tgt_lo     = cpu_req.addr >= base_r[g];
      assign tgt_hi     = cpu_req.addr <= limit_r[g];
      assign src_lo     = cpu_req.fetch_addr >= base_r[g];
      assign src_hi     = cpu_req.fetch_addr <= limit_r[g];
      assign kind_ok    = perm_r[g][rgu_pkg::PERM_MEM_LSB +: 2] == cpu_req.mem;
      assign tgt_hit[g] = live && tgt_lo && tgt_hi && kind_ok;
      assign src_hit[g] = live && src_lo && src_hi;
      assign ppbits     = perm_r[g][3:0];
      assign upbits     = perm_r[g][rgu_pkg::PERM_U_LSB +: 4];
      assign pbits      = cpu_req.priv ? ppbits : upbits;
      assign tgt_ok[g]  = pbits[cpu_req.op];
      // Fetch area is judged in the mode of the running code
      assign src_x[g]   = pbits[rgu_pkg::OP_EXEC];
    end
  endgenerate

  logic any_tgt;
  logic any_src;
  logic src_priv_exec;
  logic allow;
  logic [3:0] def_perm;
  logic       guard_en;
  logic       cfg_locked;

  assign guard_en   = ctrl_r[rgu_pkg::CTRL_EN_BIT];
  assign cfg_locked = ctrl_r[rgu_pkg::CTRL_LOCK_BIT];

  always_comb begin
    any_tgt       = |tgt_hit;
    any_src       = |src_hit;
    src_priv_exec = 1'b1;
    allow         = 1'b1;
    def_perm      = cpu_req.priv ? rgu_pkg::DEF_PRIV_PERM : rgu_pkg::DEF_USER_PERM;
    // Code fetched from an area must itself be executable there
    src_priv_exec = &(src_x | ~src_hit);
    // Every overlapping area must agree; deny wins
    if (any_tgt) begin
      allow = &(tgt_ok | ~tgt_hit);
    end else begin
      allow = def_perm[cpu_req.op];
    end
    if (any_src && !src_priv_exec) begin
      allow = 1'b0;
    end
    // A disabled guard lets every access through; software owns that choice
    if (!guard_en) begin
      allow = 1'b1;
    end
  end

  // Forward only granted accesses so denied ones never reach memory
  logic fwd;
  logic fwd_rd;
  assign fwd    = cpu_req.valid & allow;
  assign fwd_rd = fwd & (cpu_req.op == rgu_pkg::OP_READ || cpu_req.op == rgu_pkg::OP_EXEC);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_req <= '0;
    end else begin
      mem_req.valid      <= fwd;
      mem_req.op         <= cpu_req.op;
      mem_req.priv       <= cpu_req.priv;
      mem_req.addr       <= cpu_req.addr;
      mem_req.fetch_addr <= cpu_req.fetch_addr;
      mem_req.mem        <= cpu_req.mem;
      // Write data only moves with a granted access
      if (fwd) begin
        mem_req.wdata <= cpu_req.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_r    <= 1'b0;
      pend_rd_r <= 1'b0;
    end else begin
      pend_r    <= cpu_req.valid;
      pend_rd_r <= fwd_rd;
    end
  end

  // Decision is held until the next access so the answer lines up with it
  logic grant_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      grant_r <= 1'b0;
    end else if (cpu_req.valid) begin
      grant_r <= allow;
    end
  end

  logic        rsp_take;
  logic [31:0] rsp_data;

  // Denied reads return zero, never stale memory data
  assign rsp_take = pend_rd_r && mem_rvalid;
  assign rsp_data = rsp_take ? mem_rdata : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_rsp <= '0;
    end else begin
      cpu_rsp.valid <= pend_r;
      cpu_rsp.grant <= pend_r & grant_r;
      cpu_rsp.rdata <= rsp_data;
    end
  end

  // Register access decode
  logic        cfg_wr_ok;
  localparam int RAW_IDX = 2;
  logic        cfg_wr_bad;
  logic        wr_ctrl;
  logic        in_area;
  logic [RAW_IDX-1:0] area_idx;
  logic [3:0]  area_ofs;
  logic [rgu_pkg::RAW-1:0] area_rel;

  always_comb begin
    area_rel   = reg_addr - rgu_pkg::REG_AREA0;
    in_area    = reg_addr >= rgu_pkg::REG_AREA0 &&
                 area_rel < rgu_pkg::RAW'(N * rgu_pkg::AREA_STEP);
    area_idx   = area_rel[5:4];
    area_ofs   = area_rel[3:0];
    // Lock freezes the map until reset, even for privileged code
    cfg_wr_ok  = reg_wr && reg_priv && !cfg_locked;
    cfg_wr_bad = reg_wr && !cfg_wr_ok && reg_addr != rgu_pkg::REG_STATUS;
    wr_ctrl    = cfg_wr_ok && reg_addr == rgu_pkg::REG_CTRL;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= rgu_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      // Once locked this path closes as well, so only reset unlocks
      ctrl_r[rgu_pkg::CTRL_EN_BIT]   <= reg_wdata[rgu_pkg::CTRL_EN_BIT];
      ctrl_r[rgu_pkg::CTRL_LOCK_BIT] <= reg_wdata[rgu_pkg::CTRL_LOCK_BIT];
    end
  end

  generate
    for (g = 0; g < N; g++) begin : g_cfg
      logic sel;
      logic sel_base;
      logic sel_limit;
      logic sel_perm;
      assign sel       = cfg_wr_ok && in_area && area_idx == RAW_IDX'(g);
      assign sel_base  = sel && area_ofs == 4'(rgu_pkg::OFS_BASE);
      assign sel_limit = sel && area_ofs == 4'(rgu_pkg::OFS_LIMIT);
      assign sel_perm  = sel && area_ofs == 4'(rgu_pkg::OFS_PERM);

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          base_r[g] <= rgu_pkg::BASE_RST;
        end else if (sel_base) begin
          base_r[g] <= reg_wdata;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          limit_r[g] <= rgu_pkg::LIMIT_RST;
        end else if (sel_limit) begin
          limit_r[g] <= reg_wdata;
        end
      end

      // Valid bit rides in the same word, so a new area arms in one write
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          perm_r[g] <= rgu_pkg::PERM_RST[10:0];
        end else if (sel_perm) begin
          perm_r[g] <= reg_wdata[10:0];
        end
      end
    end
  endgenerate

  // Violation capture; a new block wins over a same-cycle clear
  logic blk;
  logic clr;
  assign blk = cpu_req.valid && !allow;
  assign clr = reg_wr && reg_priv && reg_addr == rgu_pkg::REG_STATUS &&
               reg_wdata[rgu_pkg::ST_VIOL_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      viol_r <= 1'b0;
    end else if (blk) begin
      viol_r <= 1'b1;
    end else if (clr) begin
      viol_r <= 1'b0;
    end
  end

  // Details follow the latest block; a clear leaves them for post-mortem reads
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vop_r   <= 2'h0;
      vpriv_r <= 1'b0;
      vaddr_r <= 32'h0000_0000;
    end else if (blk) begin
      vop_r   <= cpu_req.op;
      vpriv_r <= cpu_req.priv;
      vaddr_r <= cpu_req.addr;
    end
  end

  // Refused configuration writes are reported apart from access blocks

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vdeny_cfg_r <= 1'b0;
    end else if (cfg_wr_bad) begin
      vdeny_cfg_r <= 1'b1;
    end else if (clr) begin
      vdeny_cfg_r <= 1'b0;
    end
  end

  // Output already folds in this cycle's block and clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      viol <= 1'b0;
    end else begin
      viol <= (viol_r & ~clr) | blk;
    end
  end

  // Read port, data one cycle after the strobe
  logic [31:0] area_rd_w [N];
  logic [31:0] status_w;
  logic [31:0] area_w;
  logic [31:0] rd_nxt;

  assign status_w = {27'h000_0000, vdeny_cfg_r, vpriv_r, vop_r, viol_r};

  // One read word per area, picked by the decoded index
  generate
    for (g = 0; g < N; g++) begin : g_rd
      always_comb begin
        unique case (area_ofs)
          4'(rgu_pkg::OFS_BASE):  area_rd_w[g] = base_r[g];
          4'(rgu_pkg::OFS_LIMIT): area_rd_w[g] = limit_r[g];
          4'(rgu_pkg::OFS_PERM):  area_rd_w[g] = {21'h00_0000, perm_r[g]};
          default:                area_rd_w[g] = 32'h0000_0000;
        endcase
      end
    end
  endgenerate

  assign area_w = area_rd_w[area_idx];

  // Unmapped offsets and idle cycles read as zero, so no stale word leaks
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == rgu_pkg::REG_CTRL) begin
        rd_nxt = ctrl_r;
      end else if (reg_addr == rgu_pkg::REG_STATUS) begin
        rd_nxt = status_w;
      end else if (reg_addr == rgu_pkg::REG_VADDR) begin
        rd_nxt = vaddr_r;
      end else if (in_area) begin
        rd_nxt = area_w;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rd_nxt;
    end
  end

endmodule : rgu_top

// [sim/rgu_mem_model.sv]
module rgu_mem_model (
  input  wire logic              ref_clk,
  input  wire rgu_pkg::rgu_req_t mem_req,
  output logic [31:0]            mem_rdata,
  output logic                   mem_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] idle_r = 32'h0000_0000;
  // Answers in the request's own cycle; idle data flips so stale words show
  always_ff @(posedge ref_clk) begin
    idle_r <= ~idle_r;
  end
  assign mem_rvalid = mem_req.valid;
  assign mem_rdata  = mem_req.valid ? ~mem_req.addr : idle_r;
endmodule : rgu_mem_model

// [sim/rgu_assertions.sv]
module rgu_checker (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic [rgu_pkg::RAW-1:0] reg_addr,
  input wire logic [31:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic                    reg_priv,
  input wire logic [31:0]             reg_rdata,
  input wire rgu_pkg::rgu_req_t       cpu_req,
  input wire rgu_pkg::rgu_rsp_t       cpu_rsp,
  input wire rgu_pkg::rgu_req_t       mem_req,
  input wire logic [31:0]             mem_rdata,
  input wire logic                    mem_rvalid,
  input wire logic                    viol
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_rsp_latency: assert property (cpu_req.valid |-> ##2 cpu_rsp.valid)
    else $error("response missing two cycles after request");
  chk_no_spurious: assert property (cpu_rsp.valid |-> $past(cpu_req.valid, 2))
    else $error("response without request");
  chk_mem_gate: assert property (mem_req.valid |-> $past(cpu_req.valid) && mem_req.addr == $past(cpu_req.addr))
    else $error("memory request not from an access");
  chk_grant_match: assert property (cpu_rsp.valid |-> cpu_rsp.grant == $past(mem_req.valid))
    else $error("grant differs from memory request");
  chk_deny_data: assert property (cpu_rsp.valid && !cpu_rsp.grant |-> cpu_rsp.rdata == 32'h0000_0000)
    else $error("denied access returned data");
  chk_deny_flag: assert property (cpu_req.valid ##1 !mem_req.valid |-> viol)
    else $error("blocked access left flag low");
  chk_flag_sticky: assert property (viol && !(reg_wr && reg_priv && reg_addr == rgu_pkg::REG_STATUS) |=> viol)
    else $error("violation flag dropped");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  cover property (cpu_rsp.valid && cpu_rsp.grant);
  cover property (cpu_rsp.valid && !cpu_rsp.grant);
  cover property ($rose(viol));
endmodule : rgu_checker

bind rgu_top rgu_checker u_chk (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_priv,
  .reg_rdata, .cpu_req, .cpu_rsp, .mem_req, .mem_rdata, .mem_rvalid, .viol);

// [sim/testbench.sv]
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] B0 = rgu_pkg::REG_AREA0;
  localparam logic [7:0] L0 = B0 + 8'h04;
  localparam logic [7:0] P0 = B0 + 8'h08;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_priv = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata, mem_rdata, v;
  logic mem_rvalid, viol;
  rgu_pkg::rgu_req_t cpu_req = '0;
  rgu_pkg::rgu_req_t mem_req;
  rgu_pkg::rgu_rsp_t cpu_rsp;
  int bad_count = 0;
  int total_checks = 0;
  always #20 ref_clk = ~ref_clk;
  rgu_top uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_priv(reg_priv), .reg_rdata(reg_rdata), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .viol(viol));
  rgu_mem_model u_mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_priv, reg_wr} <= {a, d, p, 1'b1};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic acc(input logic [1:0] op, input logic pv, input logic [31:0] a, f, input logic [1:0] m,
                     input logic g);
    @(posedge ref_clk);
    cpu_req <= '{1'b1, op, pv, a, f, m, 32'h0000_1234};
    @(posedge ref_clk);
    cpu_req.valid <= 1'b0;
    #1 `CHK(mem_req.valid, g)
    @(posedge ref_clk);
    #1 `CHK(cpu_rsp.valid & cpu_rsp.grant, g)
    `CHK(cpu_rsp.rdata, (g && op[0] == op[1]) ? ~a : 32'h0000_0000)
  endtask : acc
  task automatic t_defaults();
    rd(rgu_pkg::REG_CTRL, v); `CHK(v, rgu_pkg::CTRL_RST)
    rd(P0, v); `CHK(v, rgu_pkg::PERM_RST)
    rd(8'hFC, v); `CHK(v, 32'h0000_0000)
    for (int i = 0; i < 4; i++) begin
      acc(2'(i), 1'b1, 32'h0000_0040, 32'h0, rgu_pkg::MEM_ROM, 1'b1);
      acc(2'(i), 1'b0, 32'h0000_0044, 32'h0, 2'(i % 3), 1'b0);
    end
    `CHK(viol, 1'b1)
    rd(rgu_pkg::REG_STATUS, v); `CHK(v[4:0], 5'h07)
    rd(rgu_pkg::REG_VADDR, v); `CHK(v, 32'h0000_0044)
    wr(rgu_pkg::REG_STATUS, 32'h1, 1'b0);
    rd(rgu_pkg::REG_STATUS, v); `CHK({v[4], v[0]}, 2'b01)
    wr(rgu_pkg::REG_STATUS, 32'h1, 1'b1);
    #1 `CHK(viol, 1'b0)
  endtask : t_defaults
  task automatic t_areas();
    wr(P0, 32'h0000_07FF, 1'b0);
    rd(P0, v); `CHK(v, 32'h0000_0000)
    wr(B0, 32'h0000_0100, 1'b1);
    wr(L0, 32'h0000_01FF, 1'b1);
    wr(P0, 32'h0000_051F, 1'b1);
    rd(P0, v); `CHK(v, 32'h0000_051F)
    acc(rgu_pkg::OP_READ, 1'b0, 32'h0000_01FF, 32'h0, rgu_pkg::MEM_RAM, 1'b1);
    acc(rgu_pkg::OP_READ, 1'b0, 32'h0000_0200, 32'h0, rgu_pkg::MEM_RAM, 1'b0);
    acc(rgu_pkg::OP_WRITE, 1'b0, 32'h0000_0100, 32'h0, rgu_pkg::MEM_RAM, 1'b0);
    acc(rgu_pkg::OP_READ, 1'b0, 32'h0000_0100, 32'h0, rgu_pkg::MEM_FLASH, 1'b0);
    acc(rgu_pkg::OP_READ, 1'b0, 32'h0000_0100, 32'h0000_0100, rgu_pkg::MEM_RAM, 1'b0);
    acc(rgu_pkg::OP_DELETE, 1'b1, 32'h0000_0180, 32'h0, rgu_pkg::MEM_RAM, 1'b1);
    wr(rgu_pkg::REG_CTRL, 32'h0, 1'b1);
    acc(rgu_pkg::OP_WRITE, 1'b0, 32'h0000_0100, 32'h0, rgu_pkg::MEM_RAM, 1'b1);
    wr(rgu_pkg::REG_CTRL, 32'h3, 1'b1);
    wr(P0, 32'h0000_0000, 1'b1);
    rd(P0, v); `CHK(v, 32'h0000_051F)
    rd(rgu_pkg::REG_STATUS, v); `CHK(v[4], 1'b1)
  endtask : t_areas
  task automatic t_rereset();
    do_reset();
    rd(rgu_pkg::REG_CTRL, v); `CHK(v, rgu_pkg::CTRL_RST)
    rd(P0, v); `CHK(v, 32'h0000_0000)
    acc(rgu_pkg::OP_READ, 1'b0, 32'h0000_0100, 32'h0, rgu_pkg::MEM_RAM, 1'b0);
  endtask : t_rereset
  initial begin
    do_reset();
    t_defaults();
    t_areas();
    t_rereset();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
endmodule : testbench
